/* omhi_pkg.sv */
// constants, register map and types for the display host controller
// assumes a 25 MHz system clock and an APB register port
//
// Operation
// - D/C low means command, high data
// - 6800 R/W high reads, low writes
// - 6800 device acts on E falling edge
// - 8080 write strobe low accepts bus byte
// - 8080 device drives bus only during /RD
// - module held in reset while reset low
// - device responds only while chip select low
// - two straps select one of four buses
// - 3-wire serial keeps D/C pin low
// - parallel data uses eight bidirectional lines
// - serial: host clocks data on one input
package omhi_pkg;

  // clock and pin timing, figures in ns
  localparam int CLK_NS    = 40;
  localparam int SETUP_NS  = 40;   // select and data before strobe
  localparam int STROBE_NS = 120;  // strobe active width
  localparam int HOLD_NS   = 40;   // hold after strobe release
  localparam int HALF_NS   = 80;   // serial clock half period
  // least times round up to whole cycles, never below one
  localparam logic [3:0] SETUP_CYC  = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC   = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HALF_CYC   = 4'((HALF_NS + CLK_NS - 1) / CLK_NS);

  // bus select strap codes {hi, lo}
  localparam logic [1:0] MODE_6800 = 2'h3;
  localparam logic [1:0] MODE_8080 = 2'h2;
  localparam logic [1:0] MODE_SPI3 = 2'h1;
  localparam logic [1:0] MODE_SPI4 = 2'h0;

  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CMD  = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;

  // field positions
  localparam int CTRL_MODE_LSB = 0;   // [1:0] bus mode
  localparam int CTRL_RUN_BIT  = 2;   // 1 releases module reset
  localparam int CMD_DC_BIT    = 8;   // 1 = display data
  localparam int CMD_RD_BIT    = 9;   // 1 = parallel read
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RD_LSB   = 8;   // [15:8] last read byte
  localparam int STAT_CNT_LSB  = 16;  // [31:16] finished transfers

  // values after reset
  localparam logic [1:0] CTRL_MODE_RST = MODE_SPI4;
  localparam logic       CTRL_RUN_RST  = 1'b0;

  // serial frame lengths
  localparam logic [3:0] BITS_SPI3 = 4'h9;
  localparam logic [3:0] BITS_SPI4 = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_SLOW, ST_SHIGH
  } omhi_state_type;

  // transfer pins the controller drives toward the display; module reset and straps are separate
  typedef struct packed {
    logic       csN;
    logic       dcSel;
    logic       rwWrN;     // 6800 R/W, 8080 write strobe
    logic       enRdN;     // 6800 E, 8080 read strobe
    logic [7:0] dataOut;
    logic       dataOe;
    logic       serialClk;
    logic       serialDataIn;
  } omhi_pins_type;

  localparam omhi_pins_type PINS_IDLE = '{
    csN: 1'b1, dcSel: 1'b0, rwWrN: 1'b1, enRdN: 1'b0,
    dataOut: 8'h00, dataOe: 1'b0, serialClk: 1'b0, serialDataIn: 1'b0};

endpackage : omhi_pkg

/* omhi_host.sv */
// host controller that drives the display module's bus pins
// assumes APB on clk; pins face the module, data input is asynchronous
`timescale 1ns/1ns
`default_nettype none

module omhi_host
  import omhi_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // module control pins
  output var  logic        moduleResetN,
  output var  logic        busSelectHi,
  output var  logic        busSelectLo,
  output var  logic        chipSelectN,
  output var  logic        dcSelect,
  output var  logic        rwWriteN,
  output var  logic        enableReadN,
  // parallel data bus, split into three signals
  input  wire logic [7:0]  parallelDataIn,
  output var  logic [7:0]  parallelDataOut,
  output var  logic        parallelDataOe,
  // serial pins
  output var  logic        serialClk,
  output var  logic        serialDataIn
);

  //////////////////////////////////////////////////////////////////////////
  // state
  omhi_state_type state_q, state_d;
  omhi_pins_type  pins_q, pins_d;
  logic [1:0]     mode_q, mode_d;
  logic           run_q, run_d;
  logic [3:0]     cnt_q, cnt_d;
  logic [3:0]     bits_q, bits_d;
  logic [8:0]     shift_q, shift_d;
  logic           isRead_q, isRead_d;
  logic [7:0]     rdData_q, rdData_d;
  logic [15:0]    xferCnt_q, xferCnt_d;
  logic [31:0]    prdata_q, prdata_d;
  logic [7:0]     rdSync1_q, rdSync2_q;

  logic           busy;
  logic           wrAccess;
  logic           startCmd;

  function automatic logic isSerial(input logic [1:0] m);
    isSerial = (m == MODE_SPI3) || (m == MODE_SPI4);
  endfunction : isSerial

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == ADDR_CTRL) || (a == ADDR_CMD) || (a == ADDR_STAT);
  endfunction : mapped

  assign busy     = (state_q != ST_IDLE);
  assign wrAccess = psel && penable && pwrite && mapped(paddr);
  assign startCmd = wrAccess && (paddr == ADDR_CMD) && !busy && run_q;

  //////////////////////////////////////////////////////////////////////////
  // apb: zero wait states, read data caught in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata  = prdata_q;

  always_comb
  begin
    prdata_d = prdata_q;
    if (psel && !penable)
    begin
      unique case (paddr)
        ADDR_CTRL: prdata_d = {29'h0000000, run_q, mode_q};
        ADDR_STAT: prdata_d = {xferCnt_q, rdData_q, 7'h00, busy};
        default:   prdata_d = 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control register; mode is frozen while a transfer runs, since the
  // straps must not move under a frame
  always_comb
  begin
    mode_d = mode_q;
    run_d  = run_q;
    if (wrAccess && paddr == ADDR_CTRL)
    begin
      run_d = pwdata[CTRL_RUN_BIT];
      if (!busy)
        mode_d = pwdata[CTRL_MODE_LSB +: 2];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transfer sequencer
  always_comb
  begin
    state_d   = state_q;
    pins_d    = pins_q;
    cnt_d     = cnt_q;
    bits_d    = bits_q;
    shift_d   = shift_q;
    isRead_d  = isRead_q;
    rdData_d  = rdData_q;
    xferCnt_d = xferCnt_q;
    if (cnt_q != 4'h0)
      cnt_d = cnt_q - 4'h1;
    case (state_q)
      ST_IDLE:
      begin
        pins_d = PINS_IDLE;
        pins_d.rwWrN = 1'b1;
        if (startCmd)
        begin
          pins_d.csN = 1'b0;
          pins_d.dcSel = pwdata[CMD_DC_BIT];
          if (isSerial(mode_q))
          begin
            isRead_d = 1'b0;                          // no serial read path
            if (mode_q == MODE_SPI3)
            begin
              pins_d.dcSel = 1'b0;
              shift_d = {pwdata[CMD_DC_BIT], pwdata[7:0]};
              bits_d  = BITS_SPI3;
            end
            else
            begin
              shift_d = {pwdata[7:0], 1'b0};
              bits_d  = BITS_SPI4;
            end
            pins_d.serialDataIn = (mode_q == MODE_SPI3) ?
              pwdata[CMD_DC_BIT] : pwdata[7];
            cnt_d   = HALF_CYC - 4'h1;
            state_d = ST_SLOW;
          end
          else
          begin
            isRead_d = pwdata[CMD_RD_BIT];
            if (mode_q == MODE_6800)
              pins_d.rwWrN = pwdata[CMD_RD_BIT];
            else
              pins_d.enRdN = 1'b1;  // read strobe off while selected
            pins_d.dataOut = pwdata[7:0];
            pins_d.dataOe  = !pwdata[CMD_RD_BIT];
            cnt_d   = SETUP_CYC - 4'h1;
            state_d = ST_SETUP;
          end
        end
      end
      ST_SETUP:
        if (cnt_q == 4'h0)
        begin
          if (mode_q == MODE_6800)
            pins_d.enRdN = 1'b1;                      // E rises
          else if (isRead_q)
            pins_d.enRdN = 1'b0;
          else
            pins_d.rwWrN = 1'b0;
          cnt_d   = STROBE_CYC - 4'h1;
          state_d = ST_STROBE;
        end
      ST_STROBE:
        if (cnt_q == 4'h0)
        begin
          // the synchroniser adds two cycles, so sample at strobe end
          if (isRead_q)
            rdData_d = rdSync2_q;
          pins_d.enRdN = (mode_q == MODE_6800) ? 1'b0 : 1'b1;
          if (mode_q == MODE_8080)
            pins_d.rwWrN = 1'b1;
          cnt_d   = HOLD_CYC - 4'h1;
          state_d = ST_HOLD;
        end
      ST_SLOW:
        if (cnt_q == 4'h0)
        begin
          pins_d.serialClk = 1'b1;
          cnt_d   = HALF_CYC - 4'h1;
          state_d = ST_SHIGH;
        end
      ST_SHIGH:
        if (cnt_q == 4'h0)
        begin
          pins_d.serialClk = 1'b0;
          bits_d = bits_q - 4'h1;
          cnt_d  = HALF_CYC - 4'h1;
          if (bits_q == 4'h1)
            state_d = ST_HOLD;
          else
          begin
            shift_d = {shift_q[7:0], 1'b0};
            pins_d.serialDataIn = (mode_q == MODE_SPI3) ?
              shift_q[7] : shift_q[7];
            state_d = ST_SLOW;
          end
        end
      ST_HOLD:
        if (cnt_q == 4'h0)
        begin
          pins_d    = PINS_IDLE;
          xferCnt_d = xferCnt_q + 16'h0001;
          state_d   = ST_IDLE;
        end
      default:
      begin
        pins_d  = PINS_IDLE;
        state_d = ST_IDLE;
      end
    endcase
    // losing the reset release aborts any frame in flight
    if (!run_q)
    begin
      pins_d  = PINS_IDLE;
      state_d = ST_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q   <= ST_IDLE;
      pins_q    <= PINS_IDLE;
      mode_q    <= CTRL_MODE_RST;
      run_q     <= CTRL_RUN_RST;
      cnt_q     <= 4'h0;
      bits_q    <= 4'h0;
      shift_q   <= 9'h000;
      isRead_q  <= 1'b0;
      rdData_q  <= 8'h00;
      xferCnt_q <= 16'h0000;
      prdata_q  <= 32'h00000000;
      rdSync1_q <= 8'h00;
      rdSync2_q <= 8'h00;
    end
    else
    begin
      state_q   <= state_d;
      pins_q    <= pins_d;
      mode_q    <= mode_d;
      run_q     <= run_d;
      cnt_q     <= cnt_d;
      bits_q    <= bits_d;
      shift_q   <= shift_d;
      isRead_q  <= isRead_d;
      rdData_q  <= rdData_d;
      xferCnt_q <= xferCnt_d;
      prdata_q  <= prdata_d;
      rdSync1_q <= parallelDataIn;   // first stage, read only below
      rdSync2_q <= rdSync1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin drivers, all from flip-flops
  assign moduleResetN    = run_q;
  assign busSelectHi     = mode_q[1];
  assign busSelectLo     = mode_q[0];
  assign chipSelectN     = pins_q.csN;
  assign dcSelect        = pins_q.dcSel;
  assign rwWriteN        = pins_q.rwWrN;
  assign enableReadN     = pins_q.enRdN;
  assign parallelDataOut = pins_q.dataOut;
  assign parallelDataOe  = pins_q.dataOe;
  assign serialClk       = pins_q.serialClk;
  assign serialDataIn    = pins_q.serialDataIn;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic [3:0] risesSeen_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      risesSeen_q <= 4'h0;
    else if (state_q == ST_IDLE)
      risesSeen_q <= 4'h0;
    else if (pins_d.serialClk && !pins_q.serialClk)
      risesSeen_q <= risesSeen_q + 4'h1;
  end

  a_dc_follows_cmd: assert property (
    startCmd && !isSerial(mode_q) |=> dcSelect == $past(pwdata[CMD_DC_BIT]))
    else $error("dc select does not match command");
  a_rw_read_high: assert property (
    state_q == ST_STROBE && mode_q == MODE_6800 |-> rwWriteN == isRead_q)
    else $error("6800 read/write level wrong");
  a_e_fall_cs: assert property (
    $fell(enableReadN) && mode_q == MODE_6800 |-> !chipSelectN)
    else $error("E fell without chip select");
  a_wr_drives_bus: assert property (
    mode_q == MODE_8080 && !rwWriteN |-> parallelDataOe && !chipSelectN)
    else $error("write strobe without driven bus");
  a_rd_releases_bus: assert property (
    mode_q == MODE_8080 && !enableReadN |-> !parallelDataOe)
    else $error("host drives bus during read");
  a_reset_follows: assert property (
    wrAccess && paddr == ADDR_CTRL |=>
      moduleResetN == $past(pwdata[CTRL_RUN_BIT]))
    else $error("module reset not following control");
  a_cs_idle_high: assert property (
    state_q == ST_IDLE |-> chipSelectN && enableReadN == 1'b0 && !serialClk)
    else $error("activity with chip select high");
  a_strap_stable: assert property (
    busy |=> $stable({busSelectHi, busSelectLo}))
    else $error("bus select moved during transfer");
  a_spi3_dc_low: assert property (
    mode_q == MODE_SPI3 && busy |-> !dcSelect)
    else $error("dc select not low in 3-wire mode");
  a_serial_no_oe: assert property (
    isSerial(mode_q) |-> !parallelDataOe)
    else $error("parallel bus driven in serial mode");
  a_frame_length: assert property (
    state_q == ST_HOLD && isSerial(mode_q) |->
      risesSeen_q == (mode_q == MODE_SPI3 ? BITS_SPI3 : BITS_SPI4))
    else $error("serial frame has wrong bit count");
  a_data_stable_rise: assert property (
    $rose(serialClk) |-> $stable(serialDataIn) ##1 $stable(serialDataIn))
    else $error("serial data moved at clock rise");

  c_write_6800: cover property (
    mode_q == MODE_6800 && $fell(enableReadN) && !isRead_q);
  c_read_8080: cover property (
    mode_q == MODE_8080 && state_q == ST_HOLD && isRead_q);
  c_frame_spi3: cover property (
    mode_q == MODE_SPI3 && state_q == ST_HOLD);
  c_frame_spi4: cover property (
    mode_q == MODE_SPI4 && $fell(chipSelectN));

endmodule : omhi_host

`default_nettype wire

/* omhi_disp_model.sv */
// behavioural display module that answers the host controller's pins
// assumes the bench resolves the shared data bus from both drivers
`timescale 1ns/1ns
`default_nettype none

module omhi_disp_model
  import omhi_pkg::*;
(
  // control pins from the host
  input  wire logic       moduleResetN,
  input  wire logic       busSelectHi,
  input  wire logic       busSelectLo,
  input  wire logic       chipSelectN,
  input  wire logic       dcSelect,
  input  wire logic       rwWriteN,
  input  wire logic       enableReadN,
  input  wire logic       serialClk,
  input  wire logic       serialDataIn,
  // data bus
  input  wire logic [7:0] busLevel,
  input  wire logic [7:0] readByte,
  output var  logic [7:0] devData,
  output var  logic       devOe
);
  int         logQ[$];        // {read, dc, byte} per finished transfer
  int         errCount = 0;
  int         bitCnt   = 0;
  logic [8:0] shiftV   = '0;
  logic       wrSeen   = 1'b0;
  logic       rdSeen   = 1'b0;
  wire  logic [1:0] mode = {busSelectHi, busSelectLo};

  wire  logic live = moduleResetN && !chipSelectN;

  //////////////////////////////////////////////////////////////////////
  // drive the bus only during a selected read
  always_comb
  begin
    devData = readByte;
    devOe   = live && ((mode == MODE_6800 && rwWriteN && enableReadN) ||
              (mode == MODE_8080 && !enableReadN));
  end

  //////////////////////////////////////////////////////////////////////
  // 6800: act on falling strobe, read when rw high
  always @(negedge enableReadN)
    if (live && mode == MODE_6800)
      logQ.push_back(int'({rwWriteN, dcSelect,
        rwWriteN ? readByte : busLevel}));

  // 8080: a strobe counts only if it fell while selected; the small
  // delay lets a select edge in the same step settle first
  always @(negedge rwWriteN)
  begin
    #1 wrSeen = live && mode == MODE_8080;
  end
  always @(negedge enableReadN)
  begin
    #1 rdSeen = live && mode == MODE_8080;
  end
  always @(posedge rwWriteN)
    if (wrSeen)
    begin
      logQ.push_back(int'({1'b0, dcSelect, busLevel}));
      wrSeen = 1'b0;
    end
  always @(posedge enableReadN)
    if (rdSeen)
    begin
      logQ.push_back(int'({1'b1, dcSelect, readByte}));
      rdSeen = 1'b0;
    end

  //////////////////////////////////////////////////////////////////////
  // serial: rising clock, msb first, 9 or 8 bits
  always @(posedge serialClk)
    if (live && !mode[1])
    begin
      if (mode == MODE_SPI3 && dcSelect)
        errCount++;
      shiftV = {shiftV[7:0], serialDataIn};
      bitCnt++;
      if (bitCnt == ((mode == MODE_SPI3) ? 9 : 8))
      begin
        logQ.push_back(int'({1'b0,
          (mode == MODE_SPI3) ? shiftV[8] : dcSelect, shiftV[7:0]}));
        bitCnt = 0;
      end
    end
  // a deselect or reset drops a partial frame
  always @(posedge chipSelectN or negedge moduleResetN)
    bitCnt = 0;

endmodule : omhi_disp_model

`default_nettype wire

/* test_oled_module_host_interface.sv */
// self-checking bench for the display host controller
// assumes omhi_pkg and the display model are compiled first
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module test_oled_module_host_interface
  import omhi_pkg::*;
;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [7:0]  readByte = '0;
  logic [7:0]  idlePat = 8'h00;
  wire  logic [31:0] prdata;
  wire  logic pready, pslverr, moduleResetN, busSelectHi, busSelectLo;
  wire  logic chipSelectN, dcSelect, rwWriteN, enableReadN, parallelDataOe;
  wire  logic serialClk, serialDataIn, devOe;
  wire  logic [7:0] parallelDataOut, parallelDataIn, devData;
  int   n_fail = 0;
  int   cmp_count = 0;
  int   cycles = 0;
  int   seed = 69932;

  // released bus shows a pattern that moves every cycle
  assign parallelDataIn = parallelDataOe ? parallelDataOut :
                          devOe ? devData : idlePat;

  omhi_host dut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .moduleResetN, .busSelectHi, .busSelectLo,
    .chipSelectN, .dcSelect, .rwWriteN, .enableReadN, .parallelDataIn,
    .parallelDataOut, .parallelDataOe, .serialClk, .serialDataIn);

  omhi_disp_model disp (.moduleResetN, .busSelectHi, .busSelectLo,
    .chipSelectN, .dcSelect, .rwWriteN, .enableReadN, .serialClk,
    .serialDataIn, .busLevel(parallelDataIn), .readByte, .devData, .devOe);

  //////////////////////////////////////////////////////////////////////
  // clock, idle pattern and hang limit
  initial
  begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    idlePat <= idlePat + 8'h5B;
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      results();
    end
  end
  // host may only drive the bus while it selects the module
  always @(negedge clk)
    if (arst_n && parallelDataOe)
      `CHK(chipSelectN, 1'b0)

  //////////////////////////////////////////////////////////////////////
  // one apb transfer; waits for pready with no assumed latency
  task automatic apbXfer(input logic wr, input logic [11:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apbXfer

  // poll status until the transfer is over; only the hang limit ends it
  task automatic waitIdle(output logic [31:0] s);
    logic e;
    do
      apbXfer(1'b0, ADDR_STAT, 32'h0, s, e);
    while (s[STAT_BUSY_BIT] !== 1'b0);
    `CHK(s[STAT_BUSY_BIT], 1'b0)
  endtask : waitIdle

  task automatic results();
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  //////////////////////////////////////////////////////////////////////
  // main sequence: reset, refusals, every mode, abort
  initial
  begin : mainSeq
    logic [31:0] d, s;
    logic        e, dc, rd;
    logic [7:0]  b;
    logic [1:0]  m;
    int          cnt;
    int          lg;
    int          ex;
    cnt = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    `CHK(moduleResetN, 1'b0)
    `CHK(chipSelectN, 1'b1)
    apbXfer(1'b0, 12'h00C, 32'h0, d, e);
    `CHK({e, d}, 33'h100000000)
    apbXfer(1'b1, ADDR_CMD, 32'h155, d, e); // ignored: module in reset
    apbXfer(1'b0, ADDR_CTRL, 32'h0, d, e);
    `CHK(d, 32'h00000000)
    for (int i = 0; i < 4; i++)
    begin
      m = 2'(3 - i);
      apbXfer(1'b1, ADDR_CTRL, {29'h0, 1'b1, m}, d, e);
      @(negedge clk);
      `CHK({moduleResetN, busSelectHi, busSelectLo}, {1'b1, m})
      for (int k = 0; k < 6; k++)
      begin
        b = 8'($random(seed));
        dc = 1'($random(seed));
        rd = 1'($random(seed));
        readByte <= 8'($random(seed));
        apbXfer(1'b1, ADDR_CMD, {22'h0, rd, dc, b}, d, e);
        if (k == 0)
          apbXfer(1'b1, ADDR_CMD, 32'h0FF, d, e); // busy: ignored
        waitIdle(s);
        rd = rd && m[1];
        cnt++;
        `CHK(disp.logQ.size(), 1)
        // pop once, so a mismatch report shows the same entry
        lg = disp.logQ.pop_front();
        ex = int'({rd, dc, rd ? readByte : b});
        `CHK(lg[8], dc)
        `CHK(lg, ex)
        if (rd)
          `CHK(s[15:8], readByte)
        `CHK(s[31:16], 16'(cnt))
      end
    end
    // clearing run mid-frame puts the module back in reset
    apbXfer(1'b1, ADDR_CMD, 32'h1A5, d, e);
    apbXfer(1'b1, ADDR_CTRL, 32'h0, d, e);
    // the pins fall idle one edge after the run bit drops
    repeat (2) @(negedge clk);
    `CHK({moduleResetN, chipSelectN}, 2'b01)
    waitIdle(s);
    `CHK(disp.logQ.size(), 0)
    `CHK(disp.errCount, 0)
    results();
  end

endmodule : test_oled_module_host_interface

`default_nettype wire
